// >>> src/rre_exec.sv
`timescale 1ns/1ns
// Operation
// RULE_01 - Interrupt return pops stack, sets interrupt enable
// RULE_02 - Enable is control bit 7; two cycles
// RULE_03 - Subroutine return pops into PC, two cycles
// RULE_04 - Literal return loads W, pops, two cycles
// RULE_05 - Rotate left through carry, one cycle
// RULE_06 - Destination bit selects W or file register
// RULE_07 - Each pop moves stack pointer back one
module rre_exec
   import rre_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire rre_instr_t instr,
   input wire logic instr_valid,
   input wire logic [RRE_PC_W-1:0] stack_top,
   input wire logic [RRE_DATA_W-1:0] file_rdata,
   input wire logic carry_in,
   output logic [RRE_FADDR_W-1:0] file_raddr,
   output rre_fwrite_t file_wr,
   output logic [RRE_DATA_W-1:0] working_reg,
   output logic carry_out,
   output logic carry_we,
   output logic [RRE_DATA_W-1:0] interrupt_control_reg,
   output logic [RRE_PC_W-1:0] pc,
   output logic [RRE_SP_W-1:0] stack_ptr,
   output logic pop_pulse,
   output logic busy,
   output logic done
);

   // Execution phase: second cycle of two-cycle returns
   typedef enum logic [0:0] {
      RRE_ST_IDLE = 1'b0,
      RRE_ST_SECOND = 1'b1
   } rre_state_t;

   // State of the unit: every _d is computed below, every _q is a flop
   rre_state_t state_q, state_d; // Phase
   logic [RRE_DATA_W-1:0] w_q, w_d; // Working register
   logic [RRE_DATA_W-1:0] icr_q, icr_d; // Interrupt control register
   logic [RRE_PC_W-1:0] pc_q, pc_d; // Program counter
   logic [RRE_SP_W-1:0] sp_q, sp_d; // Stack pointer
   logic carry_q, carry_d; // Carry result
   logic carry_we_q, carry_we_d; // Carry write strobe
   rre_fwrite_t fwr_q, fwr_d; // File write request
   logic [RRE_FADDR_W-1:0] raddr_q, raddr_d; // Held read address
   logic pop_q, pop_d; // Pop strobe
   logic done_q, done_d; // Completion strobe
   logic [RRE_DATA_W-1:0] rot_val; // Rotate result
   logic rot_c; // Rotate carry out
   logic busy_q, busy_d; // Busy flag, kept in a flop for a clean pin
   logic [RRE_SP_W-1:0] sp_pop; // Stack pointer one level down

   // Shared rotator, fed straight from the file read data, so the file
   // must be read in the same cycle as the op is offered
   rre_rotate #(
      .WIDTH(RRE_DATA_W)
   ) u_rot (
      .value_in(file_rdata),
      .carry_in(carry_in),
      .value_out(rot_val),
      .carry_out(rot_c)
   );

   // Stack pointer after one pop. From the bottom level it wraps to the
   // deepest level, so a stack shallower than the pointer range still
   // cycles through its own entries only. Limitation: STACK_DEPTH must
   // not exceed the pointer range, or the wrap value is cut short.
   always_comb begin
      if (sp_q == '0) begin
         // Bottom level: wrap to the deepest entry
         sp_pop = RRE_SP_W'(STACK_DEPTH - 1); // RULE_07
      end else begin
         // Any other level: one step back
         sp_pop = sp_q - 3'h1; // RULE_07
      end
   end

   // Next-state logic for the whole execution unit. A return is split in
   // two phases: the first loads the program counter and pops the stack,
   // the second is a dead cycle while the fetch unit refills from the
   // popped address. A rotate finishes in its first phase. Everything
   // defaults to hold, and all strobes default low so that each lasts
   // exactly one cycle.
   always_comb begin
      state_d = state_q;
      w_d = w_q;
      icr_d = icr_q;
      pc_d = pc_q;
      sp_d = sp_q;
      carry_d = carry_q;
      carry_we_d = 1'b0;
      fwr_d = '0;
      raddr_d = raddr_q;
      pop_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         RRE_ST_IDLE: begin
            // New instructions accepted only between operations
            // Op NONE and ops of other units fall to the default branch
            if (instr_valid) begin
               // Address kept for the file read port, whatever the op
               raddr_d = instr.faddr;
               case (instr.op)
                  RRE_OP_RETURN: begin
                     // Pop now; status untouched
                     // No increment: the popped address is the next one
                     pc_d = stack_top; // RULE_03
                     sp_d = sp_pop; // RULE_07
                     pop_d = 1'b1;
                     state_d = RRE_ST_SECOND; // RULE_03
                  end
                  RRE_OP_RETFROMIRQ: begin
                     // Back from a handler: pop and re-enable interrupts.
                     // The enable is set in the first phase, so a pending
                     // request is seen as soon as the fetch resumes.
                     pc_d = stack_top; // RULE_01
                     icr_d[RRE_GIE_BIT] = 1'b1; // RULE_02
                     // Other control bits are left as they stand
                     sp_d = sp_pop; // RULE_07
                     pop_d = 1'b1;
                     state_d = RRE_ST_SECOND; // RULE_02
                  end
                  RRE_OP_RETLIT: begin
                     // Table lookup return: literal into W, then pop
                     // Every 8-bit value is legal, so no range check
                     w_d = instr.literal; // RULE_04
                     pc_d = stack_top; // RULE_04
                     sp_d = sp_pop; // RULE_07
                     pop_d = 1'b1;
                     state_d = RRE_ST_SECOND; // RULE_04
                  end
                  RRE_OP_ROTL: begin
                     // Only carry changes among status bits
                     carry_d = rot_c; // RULE_05
                     carry_we_d = 1'b1;
                     // Single-cycle op: step to the next word
                     pc_d = pc_q + 13'h0001;
                     done_d = 1'b1; // RULE_05
                     // Destination 1: write back to the file register
                     if (instr.dest == RRE_DEST_F) begin
                        fwr_d.we = 1'b1; // RULE_06
                        fwr_d.addr = instr.faddr;
                        fwr_d.data = rot_val;
                     end else begin
                        // Destination 0: result to W, file untouched
                        w_d = rot_val; // RULE_06
                     end
                  end
                  default: begin
                     // Other operations belong to other units
                  end
               endcase
            end
         end
         RRE_ST_SECOND: begin
            // Flush cycle while the popped address is fetched
            // Offers arriving now are dropped; the issuer must retry
            done_d = 1'b1;
            state_d = RRE_ST_IDLE;
         end
         default: begin
            // Unreachable with one state bit; recover to idle
            state_d = RRE_ST_IDLE;
         end
      endcase
      // Busy follows the next phase so that the flop matches the state
      busy_d = (state_d == RRE_ST_SECOND); // RULE_03
   end

   // Registers only. Reset is synchronous; every output starts low so
   // the rest of the core sees no stray strobe on the first cycle.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= RRE_ST_IDLE;
         w_q <= RRE_W_RST;
         icr_q <= RRE_ICR_RST;
         pc_q <= RRE_PC_RST;
         sp_q <= RRE_SP_RST;
         carry_q <= 1'b0;
         carry_we_q <= 1'b0;
         fwr_q <= '0;
         raddr_q <= '0;
         pop_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         w_q <= w_d;
         icr_q <= icr_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         carry_q <= carry_d;
         carry_we_q <= carry_we_d;
         fwr_q <= fwr_d;
         raddr_q <= raddr_d;
         pop_q <= pop_d;
         done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   // Outputs straight from flip-flops
   // File register ports
   assign file_raddr = raddr_q;
   assign file_wr = fwr_q;
   // Architectural registers
   assign working_reg = w_q;
   // Status carry and its write strobe
   assign carry_out = carry_q;
   assign carry_we = carry_we_q;
   assign interrupt_control_reg = icr_q;
   // Program flow
   assign pc = pc_q;
   assign stack_ptr = sp_q;
   assign pop_pulse = pop_q;
   // Phase flag for the fetch unit
   assign busy = busy_q;
   assign done = done_q;

endmodule

// >>> pkg/rre_pkg.sv
package rre_pkg;

   // Data and address widths of the core
   localparam int RRE_DATA_W = 8;
   localparam int RRE_FADDR_W = 7;
   localparam int RRE_PC_W = 13;
   localparam int RRE_SP_W = 3;

   // Bit position of the global interrupt enable in the control register
   localparam int RRE_GIE_BIT = 7;

   // Destination select values
   localparam logic RRE_DEST_W = 1'h0;
   localparam logic RRE_DEST_F = 1'h1;

   // Cycle counts per operation
   localparam logic [1:0] RRE_CYC_RET = 2'h2;
   localparam logic [1:0] RRE_CYC_ROT = 2'h1;

   // Reset values
   localparam logic [RRE_DATA_W-1:0] RRE_W_RST = 8'h00;
   localparam logic [RRE_DATA_W-1:0] RRE_ICR_RST = 8'h00;
   localparam logic [RRE_PC_W-1:0] RRE_PC_RST = 13'h0000;
   localparam logic [RRE_SP_W-1:0] RRE_SP_RST = 3'h0;

   // Operation codes presented by the instruction decoder
   typedef enum logic [2:0] {
      RRE_OP_NONE = 3'b000,
      RRE_OP_RETURN = 3'b001,
      RRE_OP_RETFROMIRQ = 3'b010,
      RRE_OP_RETLIT = 3'b011,
      RRE_OP_ROTL = 3'b100
   } rre_op_t;

   // One decoded instruction
   typedef struct packed {
      rre_op_t op;
      logic [RRE_DATA_W-1:0] literal;
      logic [RRE_FADDR_W-1:0] faddr;
      logic dest;
   } rre_instr_t;

   // File register write request
   typedef struct packed {
      logic we;
      logic [RRE_FADDR_W-1:0] addr;
      logic [RRE_DATA_W-1:0] data;
   } rre_fwrite_t;

endpackage

// >>> src/rre_rotate.sv
`timescale 1ns/1ns
// Combinational rotate-left through carry
module rre_rotate
   import rre_pkg::*;
#(
   parameter int WIDTH = RRE_DATA_W
) (
   input wire logic [WIDTH-1:0] value_in,
   input wire logic carry_in,
   output logic [WIDTH-1:0] value_out,
   output logic carry_out
);

   // Old carry enters bit 0, old msb leaves as carry
   always_comb begin
      value_out = {value_in[WIDTH-2:0], carry_in}; // RULE_05
      carry_out = value_in[WIDTH-1]; // RULE_05
   end

endmodule

// >>> bench/rre_exec_assertions.sv
`timescale 1ns/1ns
// Port-level checker; a return is a pop plus a busy cycle
module rre_exec_checker
   import rre_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire rre_instr_t instr,
   input wire logic instr_valid,
   input wire logic [RRE_PC_W-1:0] stack_top,
   input wire logic [RRE_DATA_W-1:0] file_rdata,
   input wire logic carry_in,
   input wire rre_fwrite_t file_wr,
   input wire logic [RRE_DATA_W-1:0] working_reg,
   input wire logic carry_out,
   input wire logic carry_we,
   input wire logic [RRE_DATA_W-1:0] interrupt_control_reg,
   input wire logic [RRE_PC_W-1:0] pc,
   input wire logic [RRE_SP_W-1:0] stack_ptr,
   input wire logic pop_pulse,
   input wire logic busy,
   input wire logic done
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Request accepted at this edge
   logic tk;
   assign tk = instr_valid & ~busy;
   sequence s_ret;
      tk && instr.op inside {RRE_OP_RETURN, RRE_OP_RETFROMIRQ, RRE_OP_RETLIT};
   endsequence
   // Busy cycle, then completion
   sequence s_two;
      busy ##1 (done && !busy);
   endsequence
   a_irq_ret_gie: assert property (
      tk && instr.op == RRE_OP_RETFROMIRQ |=>
      interrupt_control_reg[RRE_GIE_BIT] && pc == $past(stack_top))
      else $error("interrupt return result wrong");
   a_ret_two_cyc: assert property (s_ret |=> s_two)
      else $error("return length wrong");
   a_ret_pc_load: assert property (
      tk && instr.op == RRE_OP_RETURN |=>
      pc == $past(stack_top) && !carry_we) else $error("return pc wrong");
   a_retlit_w: assert property (tk && instr.op == RRE_OP_RETLIT |=>
      working_reg == $past(instr.literal) && pc == $past(stack_top))
      else $error("literal return wrong");
   a_rot_carry: assert property (tk && instr.op == RRE_OP_ROTL |=>
      carry_we && done && carry_out == $past(file_rdata[7]))
      else $error("rotate carry wrong");
   a_rot_dest_f: assert property (
      tk && instr.op == RRE_OP_ROTL && instr.dest == RRE_DEST_F |=>
      file_wr.we && file_wr.data == {$past(file_rdata[6:0]), $past(carry_in)})
      else $error("rotate write wrong");
   a_rot_dest_w: assert property (
      tk && instr.op == RRE_OP_ROTL && instr.dest == RRE_DEST_W |=>
      !file_wr.we && working_reg == {$past(file_rdata[6:0]), $past(carry_in)})
      else $error("rotate w result wrong");
   a_busy_drop: assert property (busy |=>
      !carry_we && !file_wr.we && !pop_pulse)
      else $error("offer taken while busy");
   a_pop_step: assert property (s_ret |=>
      pop_pulse && stack_ptr == $past(stack_ptr) - 3'h1)
      else $error("stack step wrong");
endmodule
bind rre_exec rre_exec_checker chk (.clk_sys, .reset, .instr, .instr_valid,
   .stack_top, .file_rdata, .carry_in, .file_wr, .working_reg, .carry_out,
   .carry_we, .interrupt_control_reg, .pc, .stack_ptr, .pop_pulse, .busy,
   .done);

// >>> bench/rre_exec_test.sv
`timescale 1ns/1ns
// Directed checks of returns and rotate
module rre_exec_test;
   import rre_pkg::*;
   logic clk_sys = 0, reset = 1, instr_valid = 0, carry_in = 0;
   rre_instr_t instr = '0;
   logic [RRE_PC_W-1:0] stack_top = '0, pc;
   logic [RRE_DATA_W-1:0] file_rdata = '0, working_reg, interrupt_control_reg;
   logic [RRE_FADDR_W-1:0] file_raddr;
   rre_fwrite_t file_wr;
   logic [RRE_SP_W-1:0] stack_ptr;
   logic carry_out, carry_we, pop_pulse, busy, done;
   int fails = 0, tests_run = 0;
   rre_exec dut (
      .clk_sys(clk_sys),
      .reset(reset),
      .instr(instr),
      .instr_valid(instr_valid),
      .stack_top(stack_top),
      .file_rdata(file_rdata),
      .carry_in(carry_in),
      .file_raddr(file_raddr),
      .file_wr(file_wr),
      .working_reg(working_reg),
      .carry_out(carry_out),
      .carry_we(carry_we),
      .interrupt_control_reg(interrupt_control_reg),
      .pc(pc),
      .stack_ptr(stack_ptr),
      .pop_pulse(pop_pulse),
      .busy(busy),
      .done(done)
   );
   initial forever #10 clk_sys = ~clk_sys;
   // One comparison, counted
   task chk(string n, logic [15:0] e, logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         $display("wrong value %s exp %h got %h", n, e, s);
         fails++;
      end
   endtask
   // Offer one op for one edge; return just after the take edge settles
   task issue(rre_op_t o, logic [7:0] k, logic [6:0] f, logic d);
      @(posedge clk_sys);
      instr <= '{op: o, literal: k, faddr: f, dest: d};
      instr_valid <= 1;
      @(posedge clk_sys);
      instr_valid <= 0;
      #1;
   endtask
   task t_retlit;
      @(posedge clk_sys);
      stack_top <= 13'h1abc;
      issue(RRE_OP_RETLIT, 8'hff, 7'h00, 1'b0);
      chk("busy", 16'h0001, busy);
      chk("w", 16'h00ff, working_reg);
      chk("pc", 16'h1abc, pc);
      chk("sp", 16'h0007, stack_ptr);
      chk("pop", 16'h0001, pop_pulse);
      @(posedge clk_sys);
      #1;
      chk("done", 16'h0001, done);
      chk("busy2", 16'h0000, busy);
   endtask
   task t_return_from_interrupt_op;
      @(posedge clk_sys);
      stack_top <= 13'h0123;
      issue(RRE_OP_RETFROMIRQ, 8'h00, 7'h00, 1'b0);
      chk("icr", 16'h0080, interrupt_control_reg);
      chk("pc", 16'h0123, pc);
      chk("cwe", 16'h0000, carry_we);
      @(posedge clk_sys);
      #1;
      chk("done", 16'h0001, done);
   endtask
   // Return with a rotate offered in its busy cycle, which is ignored
   task t_return;
      @(posedge clk_sys);
      stack_top <= 13'h1fff;
      @(posedge clk_sys);
      instr <= '{op: RRE_OP_RETURN, literal: 8'h00, faddr: 7'h00, dest: 1'b0};
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      // Rotate offered in the busy cycle must be dropped
      instr <= '{op: RRE_OP_ROTL, literal: 8'h00, faddr: 7'h05, dest: 1'b1};
      #1;
      chk("busy", 16'h0001, busy);
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
      chk("done", 16'h0001, done);
      chk("pop", 16'h0000, pop_pulse);
      chk("pc", 16'h1fff, pc);
      chk("wr", 16'h0000, file_wr.we);
      chk("sp", 16'h0005, stack_ptr);
   endtask
   task t_rotl;
      @(posedge clk_sys);
      file_rdata <= 8'he6;
      issue(RRE_OP_ROTL, 8'h00, 7'h10, RRE_DEST_W);
      chk("cwe", 16'h0001, carry_we);
      chk("fwe", 16'h0000, file_wr.we);
      chk("done", 16'h0001, done);
      chk("w", 16'h00cc, working_reg);
      chk("c", 16'h0001, carry_out);
      chk("pc", 16'h0000, pc);
      @(posedge clk_sys);
      carry_in <= 1'b1;
      issue(RRE_OP_ROTL, 8'h00, 7'h7f, RRE_DEST_F);
      chk("we", 16'h0001, file_wr.we);
      chk("ra", 16'h007f, file_raddr);
      chk("fd", 16'h00cd, file_wr.data);
      chk("fa", 16'h007f, file_wr.addr);
      chk("w2", 16'h00cc, working_reg);
   endtask
   // Mid-run reset: register outputs go back to their reset values
   task t_reset;
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk("rst pc", 16'(RRE_PC_RST), pc);
      chk("rst sp", 16'(RRE_SP_RST), stack_ptr);
      chk("rst w", 16'(RRE_W_RST), working_reg);
      chk("rst icr", 16'(RRE_ICR_RST), interrupt_control_reg);
      chk("rst busy", 16'h0000, busy);
      chk("rst done", 16'h0000, done);
   endtask
   task finish_test;
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(2000 * 20);
      fails++;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 0;
      t_retlit;
      t_return_from_interrupt_op;
      t_return;
      t_rotl;
      t_reset;
      t_return_from_interrupt_op;
      finish_test;
   end
endmodule
